// ===== gdcm_top.sv
// Purpose: Pin configuration and function routing, mode-eleven start-up defaults.
// Assumes: APB slave with one wait-free access phase; pins are open to the board.
// Notes:   Pin inputs are synchronised, and debounced where the pin's debounce bit is set, before any use.
//
// Contract
// RULE1 - Pin 10 defaults to open-drain charger indicator
// RULE2 - Pin 12 defaults to CMOS line switch output
// RULE3 - Pin 11 defaults to debounced wake input
// RULE4 - Manual reset polarity bit 1 means active low
// RULE5 - Wake input polarity bit 1 means active low
// RULE6 - Ordinary functions: polarity bit 1 is active high
// RULE7 - Defaults load at start-up; software may overwrite
//
// The register addresses and register access over APB were left to the implementer.
module gdcm_top #(
  parameter int DB_CYCLES = gdcm_pkg::DB_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       nrst_i,
  // APB slave
  input  wire logic                       psel_i,
  input  wire logic                       penable_i,
  input  wire logic                       pwrite_i,
  input  wire logic [gdcm_pkg::ADDRW-1:0] paddr_i,
  input  wire logic [gdcm_pkg::DATAW-1:0] pwdata_i,
  output logic      [gdcm_pkg::DATAW-1:0] prdata_o,
  output logic                            pready_o,
  output logic                            pslverr_o,
  // Pins
  input  wire logic [gdcm_pkg::NPIN-1:0]  pin_in_i,
  output logic      [gdcm_pkg::NPIN-1:0]  pin_out_o,
  output logic      [gdcm_pkg::NPIN-1:0]  pin_oe_o,
  output logic      [gdcm_pkg::NPIN-1:0]  pin_pu_o,
  output logic      [gdcm_pkg::NPIN-1:0]  pin_pd_o,
  // Device functions
  input  wire logic                       clk32k_i,
  input  wire logic                       charger_indicator_output_i,
  input  wire logic                       line_switch_output_i,
  output logic                            manual_reset_input_o,
  output logic                            wake_input_o,
  output logic                            power_on_o
);
  localparam int NPIN = gdcm_pkg::NPIN;
  localparam int CFGW = gdcm_pkg::CFGW;
  localparam int DATAW = gdcm_pkg::DATAW;

  // Reset release through two flops.
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // Registers and pin state.
  logic [CFGW-1:0]             pin_cfg_q [NPIN];
  logic [NPIN-1:0]             dout_q;
  logic [NPIN-1:0]             din_q;
  logic [NPIN-1:0]             pin_out_q;
  logic [NPIN-1:0]             pin_oe_q;
  logic                        mr_q;
  logic                        wake_q;
  logic                        pwron_q;
  logic [DATAW-1:0]            prdata_q;
  logic [NPIN-1:0]             in_sync;
  logic [NPIN-1:0]             in_filt;
  logic [NPIN-1:0]             db_en;
  logic [NPIN-1:0]             asserted;
  logic [NPIN-1:0]             out_d;
  logic [NPIN-1:0]             oe_d;
  logic [NPIN-1:0]             pu_w;
  logic [NPIN-1:0]             pd_w;

  // Address decode.
  wire [gdcm_pkg::IDX_MSB-gdcm_pkg::IDX_LSB:0] idx = paddr_i[gdcm_pkg::IDX_MSB:gdcm_pkg::IDX_LSB];
  wire                  in_pin_area = paddr_i[gdcm_pkg::ADDRW-1:gdcm_pkg::IDX_MSB+1]
                                      == gdcm_pkg::OFS_PIN_BASE[gdcm_pkg::ADDRW-1:gdcm_pkg::IDX_MSB+1];
  wire                  hit_pin   = in_pin_area && (32'(idx) < NPIN)
                                    && paddr_i[gdcm_pkg::IDX_LSB-1:0] == 2'h0;
  wire                  hit_dout  = paddr_i == gdcm_pkg::OFS_DOUT;
  wire                  hit_din   = paddr_i == gdcm_pkg::OFS_DIN;
  wire                  hit_fstat = paddr_i == gdcm_pkg::OFS_FSTAT;
  wire                  hit_any   = hit_pin || hit_dout || hit_din || hit_fstat;
  wire                  setup_ph  = psel_i && !penable_i;
  wire                  access_ph = psel_i && penable_i;
  wire                  wr_en     = access_ph && pwrite_i && hit_any;
  wire [3:0]            idx_safe  = hit_pin ? idx : 4'h0;
  wire [gdcm_pkg::FSW-1:0] fstat  = {pwron_q, wake_q, mr_q};
  wire [DATAW-1:0]      rd_word   = hit_pin   ? {{(DATAW-CFGW){1'b0}}, pin_cfg_q[idx_safe]} :
                                    hit_dout  ? {{(DATAW-NPIN){1'b0}}, dout_q} :
                                    hit_din   ? {{(DATAW-NPIN){1'b0}}, din_q} :
                                    hit_fstat ? {{(DATAW-gdcm_pkg::FSW){1'b0}}, fstat} :
                                    32'h0000_0000;

  assign pready_o  = access_ph;
  assign pslverr_o = access_ph && !hit_any;
  assign prdata_o  = prdata_q;

  // Read data is captured in the setup cycle and stands through the access phase.
  always_ff @(posedge clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
      prdata_q <= 32'h0000_0000;
    else if (setup_ph && !pwrite_i)
      prdata_q <= rd_word;
  end

  // Configuration words take their defaults at start-up, then follow software writes.
  always_ff @(posedge clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      for (int i = 0; i < NPIN; i++)
        pin_cfg_q[i] <= gdcm_pkg::CFG_RST[i]; // RULE7 RULE1 RULE2 RULE3
      dout_q <= gdcm_pkg::DOUT_RST[NPIN-1:0];
    end
    else
    begin
      for (int i = 0; i < NPIN; i++)
        if (wr_en && hit_pin && 32'(idx) == i)
          pin_cfg_q[i] <= pwdata_i[CFGW-1:0]; // RULE7
      if (wr_en && hit_dout)
        dout_q <= pwdata_i[NPIN-1:0];
    end
  end

  // Pin input conditioning.
  gdcm_sync #(
    .W (NPIN)
  ) u_sync (
    .clk_i  (clk_i),
    .rst_ni (rst_n_q),
    .d_i    (pin_in_i),
    .q_o    (in_sync)
  );

  gdcm_debounce #(
    .W     (NPIN),
    .LIMIT (DB_CYCLES)
  ) u_debounce (
    .clk_i  (clk_i),
    .rst_ni (rst_n_q),
    .en_i   (db_en),
    .d_i    (in_sync),
    .q_o    (in_filt)
  );

  // Per-pin routing and polarity.
  for (genvar i = 0; i < NPIN; i++)
  begin : g_pin
    wire [3:0] fn   = pin_cfg_q[i][gdcm_pkg::FN_MSB:gdcm_pkg::FN_LSB];
    wire       dir  = pin_cfg_q[i][gdcm_pkg::DIR_BIT];
    wire       pcfg = pin_cfg_q[i][gdcm_pkg::CFG_BIT];
    wire       inv  = gdcm_pkg::active_low_fn(i, fn);
    wire       alt3 = fn == gdcm_pkg::FN_ALT3;
    wire       drv  = (i == gdcm_pkg::PIN_CLK32 && alt3) ? clk32k_i :
                      (i == gdcm_pkg::PIN_CHG && alt3)   ? charger_indicator_output_i : // RULE1
                      (i == gdcm_pkg::PIN_LSW && alt3)   ? line_switch_output_i :       // RULE2
                      dout_q[i];
    // Direction 0 drives; polarity bit 1 on an output selects open drain.
    assign out_d[i]    = !dir && !pcfg && drv;          // RULE2
    assign oe_d[i]     = !dir && (pcfg ? !drv : 1'b1);  // RULE1
    // A polarity bit equal to the inversion flag means active low.
    assign asserted[i] = in_filt[i] ^ (pcfg == inv);    // RULE4 RULE5 RULE6
    assign db_en[i]    = pin_cfg_q[i][gdcm_pkg::DB_BIT];
    assign pu_w[i]     = pin_cfg_q[i][gdcm_pkg::PU_BIT];
    assign pd_w[i]     = pin_cfg_q[i][gdcm_pkg::PD_BIT];
  end

  wire [3:0] fn_mr    = pin_cfg_q[gdcm_pkg::PIN_MR][gdcm_pkg::FN_MSB:gdcm_pkg::FN_LSB];
  wire [3:0] fn_wake  = pin_cfg_q[gdcm_pkg::PIN_WAKE][gdcm_pkg::FN_MSB:gdcm_pkg::FN_LSB];
  wire [3:0] fn_pwron = pin_cfg_q[gdcm_pkg::PIN_PWRON][gdcm_pkg::FN_MSB:gdcm_pkg::FN_LSB];
  wire       mr_d     = fn_mr == gdcm_pkg::FN_ALT1
                        && pin_cfg_q[gdcm_pkg::PIN_MR][gdcm_pkg::DIR_BIT]
                        && asserted[gdcm_pkg::PIN_MR];    // RULE4
  wire       wake_d   = fn_wake == gdcm_pkg::FN_ALT2
                        && pin_cfg_q[gdcm_pkg::PIN_WAKE][gdcm_pkg::DIR_BIT]
                        && asserted[gdcm_pkg::PIN_WAKE];  // RULE3 RULE5
  wire       pwron_d  = fn_pwron == gdcm_pkg::FN_ALT1
                        && pin_cfg_q[gdcm_pkg::PIN_PWRON][gdcm_pkg::DIR_BIT]
                        && asserted[gdcm_pkg::PIN_PWRON];

  always_ff @(posedge clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      pin_out_q <= '0;
      pin_oe_q  <= '0;
      din_q     <= '0;
      mr_q      <= 1'b0;
      wake_q    <= 1'b0;
      pwron_q   <= 1'b0;
    end
    else
    begin
      pin_out_q <= out_d;
      pin_oe_q  <= oe_d;
      din_q     <= asserted;
      mr_q      <= mr_d;
      wake_q    <= wake_d;
      pwron_q   <= pwron_d;
    end
  end

  assign pin_out_o            = pin_out_q;
  assign pin_oe_o             = pin_oe_q;
  assign pin_pu_o             = pu_w;
  assign pin_pd_o             = pd_w;
  assign manual_reset_input_o = mr_q;
  assign wake_input_o         = wake_q;
  assign power_on_o           = pwron_q;

  // Checks.
  wire       chg_od  = pin_cfg_q[gdcm_pkg::PIN_CHG] == gdcm_pkg::CFG_RST[gdcm_pkg::PIN_CHG];
  wire       lsw_cm  = pin_cfg_q[gdcm_pkg::PIN_LSW] == gdcm_pkg::CFG_RST[gdcm_pkg::PIN_LSW];
  wire       mr_sel  = fn_mr == gdcm_pkg::FN_ALT1 && pin_cfg_q[gdcm_pkg::PIN_MR][gdcm_pkg::DIR_BIT];
  wire       wk_sel  = fn_wake == gdcm_pkg::FN_ALT2 && pin_cfg_q[gdcm_pkg::PIN_WAKE][gdcm_pkg::DIR_BIT];
  wire [3:0] fn_p0   = pin_cfg_q[0][gdcm_pkg::FN_MSB:gdcm_pkg::FN_LSB];

  chg_default_a: assert property (@(posedge clk_i) disable iff (!rst_n_q) // RULE1
    $rose(rst_n_q) |-> pin_cfg_q[gdcm_pkg::PIN_CHG] == 9'h123)
    else $error("charger pin default wrong");

  chg_drain_a: assert property (@(posedge clk_i) disable iff (!rst_n_q) // RULE1
    (chg_od && $stable(chg_od)) |=> !pin_out_o[gdcm_pkg::PIN_CHG]
      && pin_oe_o[gdcm_pkg::PIN_CHG] == !$past(charger_indicator_output_i))
    else $error("charger pin not open drain");

  lsw_cmos_a: assert property (@(posedge clk_i) disable iff (!rst_n_q) // RULE2
    lsw_cm |=> pin_oe_o[gdcm_pkg::PIN_LSW]
      && pin_out_o[gdcm_pkg::PIN_LSW] == $past(line_switch_output_i))
    else $error("line switch pin not CMOS output");

  wake_default_a: assert property (@(posedge clk_i) disable iff (!rst_n_q) // RULE3
    $rose(rst_n_q) |-> pin_cfg_q[gdcm_pkg::PIN_WAKE] == 9'h132
      && pin_cfg_q[gdcm_pkg::PIN_LSW] == 9'h103)
    else $error("wake or line switch pin default wrong");

  mr_low_a: assert property (@(posedge clk_i) disable iff (!rst_n_q) // RULE4
    (mr_sel && pin_cfg_q[gdcm_pkg::PIN_MR][gdcm_pkg::CFG_BIT] && $stable(in_filt))
      |=> manual_reset_input_o == !$past(in_filt[gdcm_pkg::PIN_MR]))
    else $error("manual reset polarity wrong");

  wake_low_a: assert property (@(posedge clk_i) disable iff (!rst_n_q) // RULE5
    (wk_sel && pin_cfg_q[gdcm_pkg::PIN_WAKE][gdcm_pkg::CFG_BIT] && $stable(in_filt))
      |=> wake_input_o == !$past(in_filt[gdcm_pkg::PIN_WAKE]))
    else $error("wake polarity wrong");

  gpio_high_a: assert property (@(posedge clk_i) disable iff (!rst_n_q) // RULE6
    (fn_p0 == gdcm_pkg::FN_GPIO) |=> din_q[0] == ($past(in_filt[0]) ^ !$past(pin_cfg_q[0][gdcm_pkg::CFG_BIT])))
    else $error("ordinary pin polarity wrong");

  cfg_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_q) // RULE7
    (wr_en && hit_pin && idx == 4'ha) |=> pin_cfg_q[gdcm_pkg::PIN_CHG] == $past(pwdata_i[CFGW-1:0]))
    else $error("configuration write lost");

  mr_asserted_c: cover property (@(posedge clk_i) disable iff (!rst_n_q) $rose(manual_reset_input_o));
  wake_asserted_c: cover property (@(posedge clk_i) disable iff (!rst_n_q) $rose(wake_input_o));
  cfg_rewrite_c: cover property (@(posedge clk_i) disable iff (!rst_n_q) wr_en && hit_pin);
  bad_addr_c: cover property (@(posedge clk_i) disable iff (!rst_n_q) pslverr_o);
endmodule

// ===== gdcm_pkg.sv
// Purpose: Constants for the mode-eleven pin configuration block.
// Assumes: Thirteen pins, one 32-bit APB word per pin configuration.
// Notes:   Configuration word is {debounce, pull-up, pull-down, polarity, direction, function}.
package gdcm_pkg;
  localparam int NPIN = 13;
  localparam int CFGW = 9;
  localparam int ADDRW = 12;
  localparam int DATAW = 32;

  // Configuration word field positions.
  localparam int FN_LSB = 0;
  localparam int FN_MSB = 3;
  localparam int DIR_BIT = 4;
  localparam int CFG_BIT = 5;
  localparam int PD_BIT = 6;
  localparam int PU_BIT = 7;
  localparam int DB_BIT = 8;

  // Function select codes.
  localparam logic [3:0] FN_GPIO = 4'h0;
  localparam logic [3:0] FN_ALT1 = 4'h1;
  localparam logic [3:0] FN_ALT2 = 4'h2;
  localparam logic [3:0] FN_ALT3 = 4'h3;

  // Pins with a dedicated function.
  localparam int PIN_PWRON = 1;
  localparam int PIN_CLK32 = 2;
  localparam int PIN_MR = 4;
  localparam int PIN_CHG = 10;
  localparam int PIN_WAKE = 11;
  localparam int PIN_LSW = 12;

  // Start-up defaults, one word per pin.
  localparam logic [CFGW-1:0] CFG_RST [NPIN] = '{
    9'h130, 9'h111, 9'h123, 9'h130, 9'h1b1, 9'h130, 9'h130,
    9'h130, 9'h130, 9'h130, 9'h123, 9'h132, 9'h103
  };
  localparam logic [DATAW-1:0] DOUT_RST = 32'h0000_0000;

  // Register byte offsets.
  localparam logic [ADDRW-1:0] OFS_PIN_BASE = 12'h000;
  localparam logic [ADDRW-1:0] OFS_DOUT = 12'h040;
  localparam logic [ADDRW-1:0] OFS_DIN = 12'h044;
  localparam logic [ADDRW-1:0] OFS_FSTAT = 12'h048;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 5;

  // Function status bits.
  localparam int FS_MR = 0;
  localparam int FS_WAKE = 1;
  localparam int FS_PWRON = 2;
  localparam int FSW = 3;

  // Debounce filter.
  localparam int DBCW = 16;
  localparam int DB_CYCLES_DEF = 16;

  // High when a polarity bit of 1 means active low for this pin function.
  function automatic logic active_low_fn(input int pin, input logic [3:0] fn);
    active_low_fn = (pin == PIN_MR && fn == FN_ALT1) || (pin == PIN_WAKE && fn == FN_ALT2);
  endfunction
endpackage

// ===== gdcm_sync.sv
// Purpose: Two-flop synchroniser for a vector of pin levels.
// Assumes: Each bit is independent; no bus coherency is needed.
// Notes:   The first stage feeds only the second stage.
module gdcm_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_ni,
  // Data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk_i or negedge rst_ni)
  begin
    if (!rst_ni)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule

// ===== gdcm_debounce.sv
// Purpose: Per-bit debounce filter with per-bit enable.
// Assumes: Inputs are already synchronous to clk_i.
// Notes:   A level must hold LIMIT cycles before it passes; disabled bits pass at once.
module gdcm_debounce #(
  parameter int W = 1,
  parameter int LIMIT = 16
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_ni,
  // Data
  input  wire logic [W-1:0] en_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  localparam logic [gdcm_pkg::DBCW-1:0] CNT_TOP = gdcm_pkg::DBCW'(LIMIT - 1);

  logic [gdcm_pkg::DBCW-1:0] cnt_q [W];
  logic [W-1:0]              lvl_q;

  always_ff @(posedge clk_i or negedge rst_ni)
  begin
    if (!rst_ni)
    begin
      lvl_q <= '0;
      for (int i = 0; i < W; i++)
        cnt_q[i] <= '0;
    end
    else
    begin
      for (int i = 0; i < W; i++)
      begin
        if (!en_i[i] || d_i[i] == lvl_q[i])
        begin
          lvl_q[i] <= d_i[i];
          cnt_q[i] <= '0;
        end
        else if (cnt_q[i] >= CNT_TOP)
        begin
          lvl_q[i] <= d_i[i];
          cnt_q[i] <= '0;
        end
        else
          cnt_q[i] <= cnt_q[i] + 1'b1;
      end
    end
  end

  assign q_o = lvl_q;
endmodule

// ===== gdcm_board.sv
// Purpose: Board model for the thirteen pins, resolving each level from every driver.
// Assumes: The bench enables a board driver per pin; the device drives where pin_oe_i is high.
// Notes:   A floating pin with no pull shows the inverse of its last level.
module gdcm_board
(
  // Clock
  input  wire logic                      clk_i,
  // Device side
  input  wire logic [gdcm_pkg::NPIN-1:0] pin_out_i,
  input  wire logic [gdcm_pkg::NPIN-1:0] pin_oe_i,
  input  wire logic [gdcm_pkg::NPIN-1:0] pin_pu_i,
  input  wire logic [gdcm_pkg::NPIN-1:0] pin_pd_i,
  // Board side
  input  wire logic [gdcm_pkg::NPIN-1:0] ext_en_i,
  input  wire logic [gdcm_pkg::NPIN-1:0] ext_val_i,
  output logic      [gdcm_pkg::NPIN-1:0] level_o
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [gdcm_pkg::NPIN-1:0] last_q = '0;

  always_comb
  begin
    for (int i = 0; i < gdcm_pkg::NPIN; i++)
    begin
      if (pin_oe_i[i])
        level_o[i] = pin_out_i[i];
      else if (ext_en_i[i])
        level_o[i] = ext_val_i[i];
      else if (pin_pu_i[i])
        level_o[i] = 1'b1;
      else if (pin_pd_i[i])
        level_o[i] = 1'b0;
      else
        level_o[i] = ~last_q[i];
    end
  end

  always_ff @(posedge clk_i)
    last_q <= level_o;
endmodule

// ===== gpio_default_config_mode_eleven_bench.sv
// Purpose: Self-checking bench for the mode-eleven pin configuration block.
// Assumes: Short debounce length; APB master waits for pready under a bound.
// Notes:   Pin inputs come from the board model; expectations from a bench model.
module gpio_default_config_mode_eleven_bench;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int DB = 2;
  logic        clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic        pready, pslverr, e, chg = 0, lsw = 0, clk32k = 0, mr, wake, pwron;
  logic [12:0] pin_in, pin_out, pin_oe, pin_pu, pin_pd, ext_en = '0, ext_val = '0, exp_pu;
  logic [15:0] seed = 16'd31235;
  int          error_cnt = 0, checks_done = 0;
  int          cfg_m [13] = '{'h130, 'h111, 'h123, 'h130, 'h1b1, 'h130, 'h130,
                              'h130, 'h130, 'h130, 'h123, 'h132, 'h103};

  gdcm_top #(.DB_CYCLES(DB)) i_dut (.clk_i(clk), .nrst_i(nrst), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .pin_in_i(pin_in),
    .pin_out_o(pin_out), .pin_oe_o(pin_oe), .pin_pu_o(pin_pu), .pin_pd_o(pin_pd),
    .clk32k_i(clk32k), .charger_indicator_output_i(chg), .line_switch_output_i(lsw),
    .manual_reset_input_o(mr), .wake_input_o(wake), .power_on_o(pwron));

  gdcm_board i_board (.clk_i(clk), .pin_out_i(pin_out), .pin_oe_i(pin_oe),
    .pin_pu_i(pin_pu), .pin_pd_i(pin_pd), .ext_en_i(ext_en), .ext_val_i(ext_val),
    .level_o(pin_in));

  initial
  begin
    forever #20 clk = ~clk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Asserted state seen for input pins, given the board levels.
  function automatic logic [31:0] din_exp(input logic [12:0] lvl);
    logic [31:0] x;
    logic        inv;
    x = '0;
    for (int p = 0; p < 13; p++)
    begin
      inv = ((p == 4 && cfg_m[p][3:0] == 1) || (p == 11 && cfg_m[p][3:0] == 2))
            ? cfg_m[p][5] : !cfg_m[p][5];
      if (cfg_m[p][4])
        x[p] = lvl[p] ^ inv;
    end
    return x;
  endfunction

  task automatic print_verdict();
    $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      error_cnt++;
      print_verdict();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic settle();
    repeat (DB + 6) @(posedge clk);
  endtask

  initial
  begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    print_verdict();
  end

  initial
  begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    for (int p = 0; p < 13; p++)
    begin
      apb(1'b0, 12'(4 * p), '0);
      chk("cfg_reset", r, 32'(cfg_m[p]));
      if (p == 10)
        chk("pin10_cfg", r, 32'h123);
      if (p == 11)
        chk("pin11_cfg", r, 32'h132);
      if (p == 12)
        chk("pin12_cfg", r, 32'h103);
      exp_pu[p] = cfg_m[p][7];
    end
    chk("pull_up", 32'(pin_pu), 32'(exp_pu));
    chk("pull_down", 32'(pin_pd), '0);
    for (int v = 0; v < 2; v++)
    begin
      chg <= v[0];
      lsw <= v[0];
      clk32k <= v[0];
      repeat (3) @(posedge clk);
      chk("clk32k_oe", 32'(pin_oe[2]), 32'(v == 0));
      chk("chg_oe", 32'(pin_oe[10]), 32'(v == 0));
      chk("chg_level", 32'(pin_in[10] | v[0]), 32'(v[0]));
      chk("lsw_oe", 32'(pin_oe[12]), 32'h1);
      chk("lsw_out", 32'(pin_out[12]), 32'(v));
    end
    for (int v = 0; v < 2; v++)
    begin
      ext_en <= 13'h0810;
      ext_val <= {v[0], 6'h00, v[0], 4'h0};
      settle();
      chk("mr", 32'(mr), 32'(v == 0));
      chk("wake", 32'(wake), 32'(v == 0));
      apb(1'b0, 12'h048, '0);
      chk("fstat", r & 32'h3, v ? 32'h0 : 32'h3);
    end
    ext_en <= 13'h0800;
    ext_val <= 13'h0000;
    settle();
    chk("mr_pullup", 32'(mr), '0);
    // Open-drain pins are driven low so that their input levels are known.
    chg <= 1'b0;
    clk32k <= 1'b0;
    ext_en <= 13'h0bfb;
    for (int i = 0; i < 8; i++)
    begin
      if (i == 4)
      begin
        cfg_m[5] = 'h110;
        cfg_m[4] = 'h191;
        apb(1'b1, 12'h014, 32'h110);
        apb(1'b1, 12'h010, 32'h191);
        apb(1'b0, 12'h014, '0);
        chk("cfg_write", r, 32'h110);
      end
      seed = lfsr(seed);
      ext_val <= seed[12:0];
      settle();
      apb(1'b0, 12'h044, '0);
      chk("din", r, din_exp(seed[12:0]));
      chk("pwron", 32'(pwron), (din_exp(seed[12:0]) >> 1) & 32'h1);
    end
    apb(1'b0, 12'h04c, '0);
    chk("unmapped_err", 32'(e), 32'h1);
    chk("unmapped_data", r, '0);
    apb(1'b1, 12'h002, 32'h0);
    chk("misaligned_err", 32'(e), 32'h1);
    apb(1'b0, 12'h000, '0);
    chk("cfg_kept", r, 32'(cfg_m[0]));
    print_verdict();
  end
endmodule
